// [include/eat_pkg.sv]
// Purpose: Shared constants and types for the engine alarm and trip block
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register access
// Notes: Time settings count in 10 ms steps, levels in 0.1 percent steps
package eat_pkg;
    // Clock and settings step
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 10000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PRESC_W = 20;
    // Source counts and field widths
    localparam int NUM_SRC = 16;
    localparam int NUM_AIN = 3;
    localparam int DELAY_W = 13;
    localparam int LEVEL_W = 10;
    localparam int TIME_W = 14;
    localparam int RPM_W = 12;
    localparam int UA_W = 16;
    // Register byte offsets
    localparam logic [7:0] ADDR_MAJ_EN = 8'h00;
    localparam logic [7:0] ADDR_MIN_EN = 8'h04;
    localparam logic [7:0] ADDR_OPTIONS = 8'h08;
    localparam logic [7:0] ADDR_AIN_DELAY = 8'h0C;
    localparam logic [7:0] ADDR_ZERO_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_ZERO_TIME = 8'h14;
    localparam logic [7:0] ADDR_HIGH_LEVEL = 8'h18;
    localparam logic [7:0] ADDR_TRIP_RPM = 8'h1C;
    localparam logic [7:0] ADDR_CLUTCH_TIME = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_MAJ_SRC = 8'h28;
    localparam logic [7:0] ADDR_MIN_SRC = 8'h2C;
    // Option bit positions
    localparam int OPT_MINOR_OPEN = 0;
    localparam int OPT_MAJOR_OPEN = 1;
    localparam int OPT_DECLUTCH = 2;
    localparam int OPT_FUEL_CUT = 3;
    localparam int OPT_AOUT1_RANGE = 4;
    localparam int OPT_AOUT2_RANGE = 5;
    localparam int OPT_ACT2_RANGE = 6;
    localparam int OPT_RESET_ALL = 7;
    // Status bit positions
    localparam int STAT_MAJOR = 0;
    localparam int STAT_MINOR = 1;
    localparam int STAT_DECLUTCH = 2;
    localparam int STAT_FUEL_CUT = 3;
    localparam int STAT_OVERSPEED = 4;
    localparam int STAT_ZERO = 5;
    localparam int STAT_HIGH = 6;
    localparam int STAT_CLUTCH = 7;
    localparam int STAT_AIN = 8;
    // Source bit positions
    localparam int SRC_SPEED1 = 0;
    localparam int SRC_SPEED2 = 1;
    localparam int SRC_MANIFOLD = 2;
    localparam int SRC_REMOTE = 3;
    localparam int SRC_RACK = 4;
    localparam int SRC_SPEED_SW = 5;
    localparam int SRC_TORQUE = 6;
    localparam int SRC_MAN_LIM = 7;
    localparam int SRC_HIGH_ACT = 8;
    localparam int SRC_PORT2 = 9;
    localparam int SRC_PORT3 = 10;
    localparam int SRC_PORT23 = 11;
    localparam int SRC_ZERO = 12;
    localparam int SRC_OVERSPEED = 13;
    localparam int SRC_LOAD = 14;
    localparam int SRC_CLUTCH = 15;
    // Sources that hold until reset; speed switch, torque and manifold limiters and load do not
    localparam logic [15:0] LATCH_MASK = 16'hBF1F;
    // Analog failure window in microamps
    localparam logic [15:0] AIN_LOW_UA = 16'h07D0;
    localparam logic [15:0] AIN_HIGH_UA = 16'h5208;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [NUM_AIN-1:0][UA_W-1:0] eat_ain_t;

    // Engine-side status inputs, all from logic on clk_sys
    typedef struct packed {
        logic [1:0] speed_fail;
        logic speed_switch;
        logic torque_limiting;
        logic manifold_limiting;
        logic max_fuel_limiting;
        logic [1:0] link_err;
        logic load_switch;
        logic clutch_request;
        logic [LEVEL_W-1:0] ctrl_output;
        logic [RPM_W-1:0] engine_rpm;
        eat_ain_t ain_ua;
    } eat_engine_s;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } eat_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } eat_axi_rsp_s;

    typedef struct packed {
        logic [NUM_SRC-1:0] maj_en;
        logic [NUM_SRC-1:0] min_en;
        logic [7:0] opt;
        logic [DELAY_W-1:0] delay;
        logic [LEVEL_W-1:0] zlevel;
        logic [TIME_W-1:0] ztime;
        logic [LEVEL_W-1:0] hlevel;
        logic [RPM_W-1:0] trip;
        logic [TIME_W-1:0] ctime;
    } eat_cfg_s;

    // Defaults: 1 s analog delay, 2200 rpm trip, 100 percent high level, 10 s clutch time, everything else off
    localparam eat_cfg_s CFG_RST = '{maj_en: 16'h0000, min_en: 16'h0000, opt: 8'h00,
        delay: 13'h0064, zlevel: 10'h000, ztime: 14'h0000, hlevel: 10'h3E8,
        trip: 12'h898, ctime: 14'h03E8};
endpackage

// [rtl/eat_alarm_trip.sv]
// Purpose: Major and minor alarm aggregation, relays and trip requests
// Assumes: Engine status from clk_sys logic; clutch contact from a pin
// Notes: Functional notes
// Functional notes
// - Major alarm is the OR of all enabled sources, up to sixteen.
// - Each of five input failures counts only with its own enable.
// - Speed switch source follows the set point and never latches.
// - Torque and manifold limiter sources follow limiting, non-latching.
// - High actuator source follows the maximum fuel limiter when enabled.
// - Port 2, port 3 and both-ports link errors are separate sources.
// - Output-at-zero fault drives the major alarm when enabled.
// - Engine overspeed drives the major alarm when enabled.
// - Load switch source follows load above pickup, non-latching.
// - Clutch failure when engaged contact misses the sync time.
// - Analog input fails only after staying outside window for delay.
// - Minor relay energises on alarm, or opens when option set.
// - Major relay energises on alarm, or opens when option set.
// - Output-at-zero alarm requests declutch only when option set.
// - Output-at-zero trips after output stays below level for time.
// - High actuator trips when output rises above settable level.
// - Settable overspeed trip point in rpm sets the overspeed threshold.
// - Each analog output has a range select flag.
// - Second actuator output has a range select flag.
// - Rising reset command clears latched alarms whose cause is gone.
// - Major alarm forces minimum fuel when the fuel cut option is set.
`timescale 1ns/1ps
module eat_alarm_trip
    import eat_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // Register bus
    input wire eat_axi_req_s axi_req,
    output eat_axi_rsp_s axi_rsp,
    // Engine status and clutch contact pin
    input wire eat_engine_s eng,
    input wire logic clutch_engaged_pin,
    // Relays and trip requests
    output logic minor_relay,
    output logic major_relay,
    output logic declutch_req,
    output logic fuel_cut_req,
    // Range selects
    output logic analog_out1_range_sel,
    output logic analog_out2_range_sel,
    output logic actuator_out2_range_sel
);
    typedef struct packed {
        eat_cfg_s cfg;
        logic [1:0] clutch_sync;
        logic reset_prev;
        logic [PRESC_W-1:0] presc;
        logic tick;
        logic [NUM_AIN-1:0][TIME_W-1:0] ain_cnt;
        logic [NUM_AIN-1:0] ain_fail;
        logic [TIME_W-1:0] zero_cnt;
        logic zero_alarm;
        logic [TIME_W-1:0] clutch_cnt;
        logic clutch_fail;
        logic [NUM_SRC-1:0] maj_latch;
        logic [NUM_SRC-1:0] min_latch;
        logic major;
        logic minor;
        logic relay1;
        logic relay2;
        logic declutch;
        logic fuel_cut;
        logic aw_full;
        logic w_full;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        eat_axi_rsp_s rsp;
    } eat_state_s;

    localparam eat_state_s STATE_RST = '{cfg: CFG_RST, default: '0};
    localparam logic [PRESC_W-1:0] TICK_LAST = PRESC_W'(TICK_CYCLES_P - 1);

    eat_state_s s_r;
    eat_state_s s_nxt;
    logic [NUM_SRC-1:0] src;
    logic reset_rise;
    logic overspeed;
    logic high_drive;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Register readback; top bit flags a mapped address
    function automatic logic [32:0] reg_read(input eat_state_s s, input logic [7:0] addr);
        logic [32:0] res;
        res = {1'b1, 32'h00000000};
        case (addr)
            ADDR_MAJ_EN: res[15:0] = s.cfg.maj_en;
            ADDR_MIN_EN: res[15:0] = s.cfg.min_en;
            ADDR_OPTIONS: res[7:0] = s.cfg.opt;
            ADDR_AIN_DELAY: res[DELAY_W-1:0] = s.cfg.delay;
            ADDR_ZERO_LEVEL: res[LEVEL_W-1:0] = s.cfg.zlevel;
            ADDR_ZERO_TIME: res[TIME_W-1:0] = s.cfg.ztime;
            ADDR_HIGH_LEVEL: res[LEVEL_W-1:0] = s.cfg.hlevel;
            ADDR_TRIP_RPM: res[RPM_W-1:0] = s.cfg.trip;
            ADDR_CLUTCH_TIME: res[TIME_W-1:0] = s.cfg.ctime;
            ADDR_STATUS:
            begin
                res[STAT_MAJOR] = s.major;
                res[STAT_MINOR] = s.minor;
                res[STAT_DECLUTCH] = s.declutch;
                res[STAT_FUEL_CUT] = s.fuel_cut;
                res[STAT_ZERO] = s.zero_alarm;
                res[STAT_CLUTCH] = s.clutch_fail;
                res[STAT_AIN +: NUM_AIN] = s.ain_fail;
            end
            ADDR_MAJ_SRC: res[15:0] = s.maj_latch;
            ADDR_MIN_SRC: res[15:0] = s.min_latch;
            default: res = 33'h000000000;
        endcase
        return res;
    endfunction

    // Level detectors on live measurements
    // high drive level
    assign high_drive = eng.ctrl_output > s_r.cfg.hlevel;
    assign overspeed = eng.engine_rpm > s_r.cfg.trip;
    assign reset_rise = s_r.cfg.opt[OPT_RESET_ALL] & ~s_r.reset_prev;

    // Source vector, one bit per alarm cause
    always_comb
    begin
        src = '0;
        src[SRC_SPEED1] = eng.speed_fail[0];
        src[SRC_SPEED2] = eng.speed_fail[1];
        src[SRC_MANIFOLD] = s_r.ain_fail[2];
        src[SRC_REMOTE] = s_r.ain_fail[1];
        src[SRC_RACK] = s_r.ain_fail[0];
        src[SRC_SPEED_SW] = eng.speed_switch;
        src[SRC_TORQUE] = eng.torque_limiting;
        src[SRC_MAN_LIM] = eng.manifold_limiting;
        src[SRC_HIGH_ACT] = eng.max_fuel_limiting | high_drive;
        src[SRC_PORT2] = eng.link_err[0];
        src[SRC_PORT3] = eng.link_err[1];
        src[SRC_PORT23] = &eng.link_err;
        src[SRC_ZERO] = s_r.zero_alarm;
        src[SRC_OVERSPEED] = overspeed;
        src[SRC_LOAD] = eng.load_switch;
        src[SRC_CLUTCH] = s_r.clutch_fail;
    end

    // Whole next-state; ce low leaves every field as it is
    always_comb
    begin
        logic [NUM_SRC-1:0] maj_act;
        logic [NUM_SRC-1:0] min_act;
        logic [NUM_SRC-1:0] keep;
        logic [32:0] rd;
        logic [31:0] wv;
        logic out_range;
        maj_act = '0;
        min_act = '0;
        keep = '0;
        rd = '0;
        wv = '0;
        out_range = 1'b0;
        s_nxt = s_r;
        if (ce)
        begin
            // Two-flop synchroniser for the contact pin
            s_nxt.clutch_sync = {s_r.clutch_sync[0], clutch_engaged_pin};
            s_nxt.reset_prev = s_r.cfg.opt[OPT_RESET_ALL];
            // 10 ms settings tick
            s_nxt.tick = 1'b0;
            s_nxt.presc = s_r.presc + 1'b1;
            if (s_r.presc == TICK_LAST)
            begin
                s_nxt.presc = '0;
                s_nxt.tick = 1'b1;
            end
            for (int i = 0; i < NUM_AIN; i++)
            begin
                out_range = (eng.ain_ua[i] < AIN_LOW_UA) || (eng.ain_ua[i] > AIN_HIGH_UA);
                if (!out_range)
                begin
                    s_nxt.ain_cnt[i] = '0;
                    s_nxt.ain_fail[i] = 1'b0;
                end
                else if (s_r.ain_cnt[i] >= TIME_W'(s_r.cfg.delay))
                begin
                    s_nxt.ain_fail[i] = 1'b1;
                end
                else if (s_r.tick)
                begin
                    s_nxt.ain_cnt[i] = s_r.ain_cnt[i] + 1'b1;
                end
            end
            if (eng.ctrl_output >= s_r.cfg.zlevel)
            begin
                s_nxt.zero_cnt = '0;
                s_nxt.zero_alarm = 1'b0;
            end
            else if (s_r.zero_cnt >= s_r.cfg.ztime)
            begin
                s_nxt.zero_alarm = 1'b1;
            end
            else if (s_r.tick)
            begin
                s_nxt.zero_cnt = s_r.zero_cnt + 1'b1;
            end
            if (!eng.clutch_request || s_r.clutch_sync[1])
            begin
                s_nxt.clutch_cnt = '0;
                s_nxt.clutch_fail = 1'b0;
            end
            else if (s_r.clutch_cnt >= s_r.cfg.ctime)
            begin
                s_nxt.clutch_fail = 1'b1;
            end
            else if (s_r.tick)
            begin
                s_nxt.clutch_cnt = s_r.clutch_cnt + 1'b1;
            end
            // clear only causes that are gone
            keep = reset_rise ? src : {NUM_SRC{1'b1}};
            // latch held, new cause wins over clear
            maj_act = src & s_r.cfg.maj_en;
            min_act = src & s_r.cfg.min_en;
            s_nxt.maj_latch = (maj_act | (s_r.maj_latch & keep)) & LATCH_MASK;
            s_nxt.min_latch = (min_act | (s_r.min_latch & keep)) & LATCH_MASK;
            s_nxt.major = |(s_nxt.maj_latch | maj_act);
            s_nxt.minor = |(s_nxt.min_latch | min_act);
            s_nxt.relay1 = s_nxt.minor ^ s_r.cfg.opt[OPT_MINOR_OPEN];
            s_nxt.relay2 = s_nxt.major ^ s_r.cfg.opt[OPT_MAJOR_OPEN];
            s_nxt.declutch = s_nxt.zero_alarm & s_r.cfg.opt[OPT_DECLUTCH];
            s_nxt.fuel_cut = s_nxt.major & s_r.cfg.opt[OPT_FUEL_CUT];

            // Write channels are taken independently, in either order
            if (axi_req.awvalid && s_r.rsp.awready)
            begin
                s_nxt.aw_full = 1'b1;
                s_nxt.aw_addr = axi_req.awaddr;
            end
            if (axi_req.wvalid && s_r.rsp.wready)
            begin
                s_nxt.w_full = 1'b1;
                s_nxt.w_data = axi_req.wdata;
                s_nxt.w_strb = axi_req.wstrb;
            end
            if (s_r.rsp.bvalid && axi_req.bready)
            begin
                s_nxt.rsp.bvalid = 1'b0;
            end
            // settings change only on a clocked write
            if (s_r.aw_full && s_r.w_full && !s_r.rsp.bvalid)
            begin
                rd = reg_read(s_r, s_r.aw_addr);
                wv = merge(rd[31:0], s_r.w_data, s_r.w_strb);
                s_nxt.aw_full = 1'b0;
                s_nxt.w_full = 1'b0;
                s_nxt.rsp.bvalid = 1'b1;
                s_nxt.rsp.bresp = RESP_OKAY;
                case (s_r.aw_addr)
                    ADDR_MAJ_EN: s_nxt.cfg.maj_en = wv[15:0];
                    ADDR_MIN_EN: s_nxt.cfg.min_en = wv[15:0];
                    ADDR_OPTIONS: s_nxt.cfg.opt = wv[7:0];
                    ADDR_AIN_DELAY: s_nxt.cfg.delay = wv[DELAY_W-1:0];
                    ADDR_ZERO_LEVEL: s_nxt.cfg.zlevel = wv[LEVEL_W-1:0];
                    ADDR_ZERO_TIME: s_nxt.cfg.ztime = wv[TIME_W-1:0];
                    ADDR_HIGH_LEVEL: s_nxt.cfg.hlevel = wv[LEVEL_W-1:0];
                    ADDR_TRIP_RPM: s_nxt.cfg.trip = wv[RPM_W-1:0];
                    ADDR_CLUTCH_TIME: s_nxt.cfg.ctime = wv[TIME_W-1:0];
                    default: s_nxt.rsp.bresp = RESP_SLVERR;
                endcase
            end
            s_nxt.rsp.awready = !s_nxt.aw_full && !s_nxt.rsp.bvalid;
            s_nxt.rsp.wready = !s_nxt.w_full && !s_nxt.rsp.bvalid;
            // Read answers the cycle after the address is taken
            if (s_r.rsp.rvalid && axi_req.rready)
            begin
                s_nxt.rsp.rvalid = 1'b0;
            end
            if (axi_req.arvalid && s_r.rsp.arready)
            begin
                rd = reg_read(s_r, axi_req.araddr);
                s_nxt.rsp.rvalid = 1'b1;
                s_nxt.rsp.rdata = rd[31:0];
                s_nxt.rsp.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
            end
            s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_r <= STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flops
    assign axi_rsp = s_r.rsp;
    assign minor_relay = s_r.relay1;
    assign major_relay = s_r.relay2;
    assign declutch_req = s_r.declutch;
    assign fuel_cut_req = s_r.fuel_cut;
    assign analog_out1_range_sel = s_r.cfg.opt[OPT_AOUT1_RANGE];
    assign analog_out2_range_sel = s_r.cfg.opt[OPT_AOUT2_RANGE];
    assign actuator_out2_range_sel = s_r.cfg.opt[OPT_ACT2_RANGE];

    // Checks on alarm behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    AST_MAJOR_OR: assert property (ce && |(src & s_r.cfg.maj_en) |=> s_r.major)
        else $error("enabled source did not raise major alarm");
    AST_FAIL_MASK: assert property (ce && !s_r.cfg.maj_en[SRC_SPEED1]
        && !s_r.maj_latch[SRC_SPEED1] |=> !s_r.maj_latch[SRC_SPEED1])
        else $error("disabled speed sensor failure latched");
    AST_NONLATCH: assert property (ce && ((src & s_r.cfg.maj_en) == 16'h0000)
        && (s_r.maj_latch == 16'h0000) |=> !s_r.major)
        else $error("major alarm held with no cause");
    AST_AIN_DELAY: assert property ($rose(s_r.ain_fail[0])
        |-> $past(s_r.ain_cnt[0]) >= TIME_W'($past(s_r.cfg.delay)))
        else $error("analog failure declared before delay");
    AST_MAJ_RELAY: assert property (ce |=>
        s_r.relay2 == (s_r.major ^ $past(s_r.cfg.opt[OPT_MAJOR_OPEN])))
        else $error("major relay polarity wrong");
    AST_DECLUTCH: assert property (ce && !s_r.cfg.opt[OPT_DECLUTCH] |=> !s_r.declutch)
        else $error("declutch without option");
    AST_ZERO_TIME: assert property ($rose(s_r.zero_alarm)
        |-> $past(s_r.zero_cnt) >= $past(s_r.cfg.ztime))
        else $error("output zero alarm too early");
    AST_OVERSPEED: assert property (ce && s_r.cfg.maj_en[SRC_OVERSPEED] && overspeed
        |=> s_r.major ##0 s_r.maj_latch[SRC_OVERSPEED])
        else $error("overspeed did not trip");
    AST_RESET_ALL: assert property (ce && reset_rise && (src == 16'h0000)
        |=> s_r.maj_latch == 16'h0000 && !s_r.major)
        else $error("reset all left an alarm latched");
    AST_FUEL_CUT: assert property (ce |=>
        s_r.fuel_cut == (s_r.major && $past(s_r.cfg.opt[OPT_FUEL_CUT])))
        else $error("fuel cut does not follow major alarm");
    AST_LATCH_HOLD: assert property (ce && s_r.maj_latch[SRC_SPEED1] && !reset_rise
        |=> s_r.maj_latch[SRC_SPEED1])
        else $error("latched alarm dropped without reset");

    // Main scenarios
    COV_MAJOR: cover property (!s_r.major ##1 s_r.major ##[1:20] !s_r.major);
    COV_AIN_FAIL: cover property ($rose(s_r.ain_fail[1]));
    COV_DECLUTCH: cover property ($rose(s_r.declutch));
    COV_WRITE: cover property (s_r.rsp.bvalid && axi_req.bready);
endmodule

// [bench/eat_engine_model.sv]
// Purpose: Engine side stand-in driving status and clutch contact
// Assumes: Bench sets fault bits and speed; levels change off the edge
// Notes: Analog currents sit mid-window so no input failure appears
`timescale 1ns/1ps
module eat_engine_model
    import eat_pkg::*;
(
    // Commands from the bench
    input wire logic [7:0] flt,
    input wire logic [RPM_W-1:0] rpm,
    // Status towards the block
    output eat_engine_s eng,
    output logic clutch_engaged_pin
);
    // Clean levels; output kept at 50 percent, between both detectors
    always_comb
    begin
        eng = '{speed_fail: flt[1:0], speed_switch: flt[2], torque_limiting: flt[3],
            manifold_limiting: 1'b0, max_fuel_limiting: 1'b0, link_err: flt[5:4],
            load_switch: flt[6], clutch_request: 1'b0, ctrl_output: 10'h1F4,
            engine_rpm: rpm, ain_ua: {3{16'h2710}}};
        clutch_engaged_pin = flt[7];
    end
endmodule

// [bench/testbench.sv]
// Purpose: Register and alarm path checks of the alarm and trip block
// Assumes: bready and rready held high, legal for a master
// Notes: Short tick so timed detectors stay cheap
`timescale 1ns/1ps
module testbench
    import eat_pkg::*;
;
    logic clk_sys, reset, ce, clutch_pin;
    eat_axi_req_s rq;
    eat_axi_rsp_s rp;
    eat_engine_s eng;
    logic [7:0] flt;
    logic [RPM_W-1:0] rpm;
    logic maj_r, min_r, decl, fcut, ao1, ao2, act2;
    logic [31:0] obs;
    int error_cnt, n_compared;
    assign obs = {25'h0, ao1, ao2, act2, fcut, decl, min_r, maj_r};
    eat_engine_model eng_u (.flt(flt), .rpm(rpm), .eng(eng), .clutch_engaged_pin(clutch_pin));
    eat_alarm_trip #(.TICK_CYCLES_P(4)) dut_u (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .axi_req(rq), .axi_rsp(rp), .eng(eng), .clutch_engaged_pin(clutch_pin),
        .minor_relay(min_r), .major_relay(maj_r), .declutch_req(decl), .fuel_cut_req(fcut),
        .analog_out1_range_sel(ao1), .analog_out2_range_sel(ao2),
        .actuator_out2_range_sel(act2));
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop;
        $display("Errors %0d, compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait; running out ends the run
    task automatic tick(inout int n);
        @(posedge clk_sys);
        n++;
        if (n > 50)
        begin
            error_cnt++;
            $display("BAD %0t bus hang", $time);
            report_and_stop();
        end
    endtask
    // Write: both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] xr);
        int n;
        bit got;
        n = 0;
        got = 1'b0;
        rq.awaddr <= a;
        rq.wdata <= d;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        while (!got)
        begin
            tick(n);
            if (rp.awready)
                rq.awvalid <= 1'b0;
            if (rp.wready)
                rq.wvalid <= 1'b0;
            got = rp.bvalid;
        end
        chk({30'h0, rp.bresp}, {30'h0, xr});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] xd, input logic [1:0] xr);
        int n;
        bit got;
        n = 0;
        got = 1'b0;
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        while (!got)
        begin
            tick(n);
            if (rp.arready)
                rq.arvalid <= 1'b0;
            got = rp.rvalid;
        end
        chk(rp.rdata, xd);
        chk({30'h0, rp.rresp}, {30'h0, xr});
    endtask
    // Set engine faults, then let the one-cycle alarm path land
    task automatic eng_set(input logic [7:0] f);
        flt <= f;
        repeat (3) @(posedge clk_sys);
    endtask
    // Main sequence
    initial
    begin
        error_cnt = 0;
        n_compared = 0;
        rq = '0;
        rq.wstrb = 4'hF;
        rq.bready = 1'b1;
        rq.rready = 1'b1;
        reset = 1'b1;
        ce = 1'b1;
        flt = 8'h00;
        rpm = 12'h064;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk(obs, 32'h0);
        rd(ADDR_TRIP_RPM, 32'h898, RESP_OKAY);
        rd(ADDR_AIN_DELAY, 32'h64, RESP_OKAY);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
        wr(ADDR_MAJ_EN, 32'h2222, RESP_OKAY);
        eng_set(8'h09);
        chk(obs, 32'h0);
        eng_set(8'h04);
        chk(obs, 32'h1);
        eng_set(8'h00);
        chk(obs, 32'h0);
        eng_set(8'h10);
        chk(obs, 32'h1);
        eng_set(8'h00);
        chk(obs, 32'h1);
        rd(ADDR_MAJ_SRC, 32'h200, RESP_OKAY);
        wr(ADDR_OPTIONS, 32'h00, RESP_OKAY);
        wr(ADDR_OPTIONS, 32'h80, RESP_OKAY);
        eng_set(8'h00);
        chk(obs, 32'h0);
        wr(ADDR_TRIP_RPM, 32'h064, RESP_OKAY);
        rpm <= 12'h065;
        eng_set(8'h00);
        chk(obs, 32'h1);
        wr(ADDR_OPTIONS, 32'h08, RESP_OKAY);
        eng_set(8'h00);
        chk(obs, 32'h9);
        wr(ADDR_OPTIONS, 32'h0A, RESP_OKAY);
        eng_set(8'h00);
        chk(obs, 32'h8);
        wr(ADDR_MIN_EN, 32'h20, RESP_OKAY);
        eng_set(8'h04);
        chk(obs, 32'hA);
        wr(ADDR_OPTIONS, 32'h0B, RESP_OKAY);
        eng_set(8'h04);
        chk(obs, 32'h8);
        wr(ADDR_OPTIONS, 32'h70, RESP_OKAY);
        eng_set(8'h04);
        chk(obs, 32'h73);
        wr(ADDR_ZERO_TIME, 32'h2, RESP_OKAY);
        wr(ADDR_OPTIONS, 32'h04, RESP_OKAY);
        wr(ADDR_ZERO_LEVEL, 32'h3E8, RESP_OKAY);
        repeat (20) @(posedge clk_sys);
        chk(obs, 32'h7);
        rd(ADDR_STATUS, 32'h27, RESP_OKAY);
        wr(ADDR_OPTIONS, 32'h00, RESP_OKAY);
        eng_set(8'h04);
        chk(obs, 32'h3);
        report_and_stop();
    end
endmodule
